// >>> design/pcoc_defs.vh
`ifndef PCOC_DEFS_VH
`define PCOC_DEFS_VH

// ----------------------------------------------------------------------
// Register offsets (serial control port addresses)
// ----------------------------------------------------------------------
`define PCOC_ADDR_BIAS      15'h003F
`define PCOC_ADDR_PREEMPH   15'h0048
`define PCOC_ADDR_AUXCTL    15'h0057
`define PCOC_ADDR_OVR       15'h0058

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PCOC_RST_BIAS       8'h4F
`define PCOC_RST_PREEMPH    8'h00
`define PCOC_RST_AUXCTL     8'h00
`define PCOC_RST_OVR        8'h00

// ----------------------------------------------------------------------
// Writable bit masks (reserved bits read as zero)
// ----------------------------------------------------------------------
`define PCOC_MASK_BIAS      8'h7F
`define PCOC_MASK_PREEMPH   8'h0F
`define PCOC_MASK_AUXCTL    8'h87
`define PCOC_MASK_OVR       8'hBF

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PCOC_BIAS_MSB       6
`define PCOC_PE_MSB         3
`define PCOC_AUX_EN_BIT     7
`define PCOC_AUX_SEL_MSB    2
`define PCOC_OVR_EN_BIT     7
`define PCOC_D_SEL_MSB      5
`define PCOC_D_SEL_LSB      4
`define PCOC_C_SEL_MSB      3
`define PCOC_C_SEL_LSB      2
`define PCOC_SE_REF_BIT     1
`define PCOC_SYN_EN_BIT     0

// ----------------------------------------------------------------------
// Output select codes
// ----------------------------------------------------------------------
`define PCOC_AUX_16UI       3'h0
`define PCOC_AUX_32UI       3'h1
`define PCOC_AUX_64UI       3'h2
`define PCOC_AUX_TSTAMP     3'h3
`define PCOC_REF_OFF        2'h0
`define PCOC_REF_DIV1       2'h1
`define PCOC_REF_DIV2       2'h2
`define PCOC_REF_DIV4       2'h3

// ----------------------------------------------------------------------
// Divider half periods in clk cycles
// ----------------------------------------------------------------------
`define PCOC_HALF_16UI      6'h08
`define PCOC_HALF_32UI      6'h10
`define PCOC_HALF_64UI      6'h20
`define PCOC_HALF_DIV1      6'h01
`define PCOC_HALF_DIV2      6'h02
`define PCOC_HALF_DIV4      6'h04

// ----------------------------------------------------------------------
// Serial frame layout
// ----------------------------------------------------------------------
`define PCOC_FRAME_HDR      5'h0F
`define PCOC_FRAME_LAST     5'h17
`define PCOC_LANES          8

`endif

// >>> design/pcoc_clk_div.v
`timescale 1ns/10ps
`include "pcoc_defs.vh"

module pcoc_clk_div
(
    input  wire       clk,          // System clock
    input  wire       rst_n,        // Synchronous reset, active low
    input  wire       enable,       // Request the divided clock
    input  wire       restart,      // Drop output low and restart phase
    input  wire [5:0] half_period,  // Cycles per half period, nonzero
    output reg        clk_out,      // Divided clock, low when idle
    output reg        active        // Divider is producing a clock
);

    reg [5:0] cnt_r;
    reg [5:0] half_r;

    // ------------------------------------------------------------------
    // Divider core
    // ------------------------------------------------------------------
    // Enable starts and stops it only with the output low, so only restart can cut a pulse;
    // the half period is latched per phase so a ratio change never cuts
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            cnt_r   <= 6'h00;
            half_r  <= `PCOC_HALF_DIV1;
            clk_out <= 1'b0;
            active  <= 1'b0;
        end
        else if (restart)
        begin
            cnt_r   <= 6'h00;
            half_r  <= half_period;
            clk_out <= 1'b0;
        end
        else if (!active)
        begin
            cnt_r   <= 6'h00;
            half_r  <= half_period;
            clk_out <= 1'b0;
            active  <= enable;
        end
        else if (cnt_r == half_r - 6'h01)
        begin
            cnt_r  <= 6'h00;
            half_r <= half_period;
            if (clk_out)
            begin
                clk_out <= 1'b0;
                active  <= enable;
            end
            else if (enable)
                clk_out <= 1'b1;
            else
                active  <= 1'b0;
        end
        else
            cnt_r <= cnt_r + 6'h01;
    end

endmodule

// >>> design/pcoc_top.v
`timescale 1ns/10ps
`include "pcoc_defs.vh"

module pcoc_top
(
    input  wire        clk,                    // System clock, 40 MHz
    input  wire        rst_n,                  // Sync reset, active low
    input  wire        spi_sclk,               // Serial port clock pin
    input  wire        spi_cs_n,               // Serial port select
    input  wire        spi_sdi,                // Serial data in
    output reg         spi_sdo,                // Serial data out
    output wire        spi_sdo_oe,             // Data out drive enable
    input  wire        synth_enable_pin,       // Synth enable pin
    input  wire        ref_select_pin,         // Reference select pin
    input  wire        clock_config_pin_0,     // Clock config pin 0
    input  wire        clock_config_pin_1,     // Clock config pin 1
    input  wire        timestamp_input,        // Timestamp pin
    input  wire        ser_reinit,             // Serializer restart
    output reg  [6:0]  oscillator_bias_level,  // Oscillator bias
    output reg  [31:0] lane_preemphasis,       // 4 bits per lane
    output reg         synth_enable,           // Synthesizer enable
    output reg         single_ended_ref_sel,   // Single-ended ref used
    output wire        aux_output_pin,         // Trigger output
    output wire        ref_output_c,           // Divided ref output C
    output wire        ref_output_d            // Divided ref output D
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    reg  [7:0]  bias_r;
    reg  [7:0]  preemph_r;
    reg  [7:0]  auxctl_r;
    reg  [7:0]  ovr_r;
    reg  [7:0]  sync1_r;
    reg  [7:0]  sync2_r;
    reg         sclk_d_r;
    reg  [4:0]  bit_cnt_r;
    reg  [15:0] hdr_r;
    reg  [7:0]  wdata_r;
    reg  [7:0]  rshift_r;
    reg         reading_r;
    reg  [7:0]  rd_data;
    reg  [7:0]  wr_byte;
    reg  [14:0] wr_addr;
    reg  [1:0]  c_sel;
    reg  [1:0]  d_sel;
    reg  [5:0]  c_half;
    reg  [5:0]  d_half;
    reg  [5:0]  aux_half;
    reg  [2:0]  aux_sel_d_r;
    reg         tstamp_out_r;
    wire        sclk_s;
    wire        cs_n_s;
    wire        sdi_s;
    wire        syn_pin_s;
    wire        ref_pin_s;
    wire        cfg0_s;
    wire        cfg1_s;
    wire        tstamp_s;
    wire        sclk_rise;
    wire        sclk_fall;
    wire        wr_commit;
    wire        ovr_en;
    wire        aux_en;
    wire [2:0]  aux_sel;
    wire        aux_clk_mode;
    wire        aux_clk;
    wire        c_active;
    wire        d_active;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // Two flops on every pin except ser_reinit; only the second stage is read
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            sync1_r <= 8'h03;
            sync2_r <= 8'h03;
        end
        else
        begin
            sync1_r <= {timestamp_input, clock_config_pin_1,
                        clock_config_pin_0, ref_select_pin,
                        synth_enable_pin, spi_sdi, spi_cs_n, spi_sclk};
            sync2_r <= sync1_r;
        end
    end

    assign sclk_s    = sync2_r[0];
    assign cs_n_s    = sync2_r[1];
    assign sdi_s     = sync2_r[2];
    assign syn_pin_s = sync2_r[3];
    assign ref_pin_s = sync2_r[4];
    assign cfg0_s    = sync2_r[5];
    assign cfg1_s    = sync2_r[6];
    assign tstamp_s  = sync2_r[7];

    // Serial clock edge detection on the synchronised level
    always @(posedge clk)
    begin
        if (!rst_n)
            sclk_d_r <= 1'b0;
        else
            sclk_d_r <= sclk_s;
    end

    assign sclk_rise = sclk_s & ~sclk_d_r & ~cs_n_s;
    assign sclk_fall = ~sclk_s & sclk_d_r & ~cs_n_s;

    // ------------------------------------------------------------------
    // Serial control port
    // ------------------------------------------------------------------
    // Frame: read flag, 15-bit address, 8 data bits, MSB first
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            bit_cnt_r <= 5'h00;
            hdr_r     <= 16'h0000;
            wdata_r   <= 8'h00;
            rshift_r  <= 8'h00;
            reading_r <= 1'b0;
            spi_sdo   <= 1'b0;
        end
        else if (cs_n_s)
        begin
            bit_cnt_r <= 5'h00;
            reading_r <= 1'b0;
            spi_sdo   <= 1'b0;
        end
        else
        begin
            if (sclk_rise)
            begin
                if (bit_cnt_r != 5'h1F)
                    bit_cnt_r <= bit_cnt_r + 5'h01;
                if (bit_cnt_r <= `PCOC_FRAME_HDR)
                    hdr_r <= {hdr_r[14:0], sdi_s};
                else
                    wdata_r <= {wdata_r[6:0], sdi_s};
                if (bit_cnt_r == `PCOC_FRAME_HDR)
                begin
                    reading_r <= hdr_r[14];
                    rshift_r  <= rd_data;
                end
            end
            if (sclk_fall && reading_r &&
                bit_cnt_r > `PCOC_FRAME_HDR &&
                bit_cnt_r <= `PCOC_FRAME_LAST + 5'h01)
            begin
                spi_sdo  <= rshift_r[7];
                rshift_r <= {rshift_r[6:0], 1'b0};
            end
        end
    end

    assign spi_sdo_oe = reading_r & ~cs_n_s;

    // Write commits on the last data bit of a write frame
    assign wr_commit = sclk_rise & ~hdr_r[15] &
                       (bit_cnt_r == `PCOC_FRAME_LAST);

    // Read mux; the address is complete when the header bit arrives
    always @*
    begin
        case ({hdr_r[13:0], sdi_s})
            `PCOC_ADDR_BIAS:    rd_data = bias_r;
            `PCOC_ADDR_PREEMPH: rd_data = preemph_r;
            `PCOC_ADDR_AUXCTL:  rd_data = auxctl_r;
            `PCOC_ADDR_OVR:     rd_data = ovr_r;
            default:            rd_data = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    always @*
    begin
        wr_byte = {wdata_r[6:0], sdi_s};
        wr_addr = hdr_r[14:0];
    end

    // Reserved bits are masked so they always read zero
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            bias_r    <= `PCOC_RST_BIAS;
            preemph_r <= `PCOC_RST_PREEMPH;
            auxctl_r  <= `PCOC_RST_AUXCTL;
            ovr_r     <= `PCOC_RST_OVR;
        end
        else if (wr_commit)
        begin
            case (wr_addr)
                `PCOC_ADDR_BIAS:
                    bias_r <= wr_byte & `PCOC_MASK_BIAS;
                `PCOC_ADDR_PREEMPH:
                    preemph_r <= wr_byte & `PCOC_MASK_PREEMPH;
                `PCOC_ADDR_AUXCTL:
                    auxctl_r <= wr_byte & `PCOC_MASK_AUXCTL;
                `PCOC_ADDR_OVR:
                    ovr_r <= wr_byte & `PCOC_MASK_OVR;
                default:
                    bias_r <= bias_r;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Synthesizer control outputs
    // ------------------------------------------------------------------
    assign ovr_en = ovr_r[`PCOC_OVR_EN_BIT];

    // Pin or register source for enable and reference choice
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            oscillator_bias_level <= 7'h4F;
            lane_preemphasis      <= 32'h0000_0000;
            synth_enable          <= 1'b0;
            single_ended_ref_sel  <= 1'b0;
        end
        else
        begin
            oscillator_bias_level <= bias_r[`PCOC_BIAS_MSB:0];
            lane_preemphasis <= {`PCOC_LANES{preemph_r[`PCOC_PE_MSB:0]}};
            synth_enable <= ovr_en ? ovr_r[`PCOC_SYN_EN_BIT]
                                   : syn_pin_s;
            single_ended_ref_sel <= ovr_en ? ovr_r[`PCOC_SE_REF_BIT]
                                           : ref_pin_s;
        end
    end

    // ------------------------------------------------------------------
    // Divided reference outputs
    // ------------------------------------------------------------------
    // Pin mode maps the config pins to C; pin 1 also mirrors C onto D
    always @*
    begin
        if (ovr_en)
        begin
            c_sel = ovr_r[`PCOC_C_SEL_MSB:`PCOC_C_SEL_LSB];
            d_sel = ovr_r[`PCOC_D_SEL_MSB:`PCOC_D_SEL_LSB];
        end
        else
        begin
            c_sel = {cfg1_s, cfg0_s};
            d_sel = cfg1_s ? {cfg1_s, cfg0_s}
                           : `PCOC_REF_OFF;
        end
        case (c_sel)
            `PCOC_REF_DIV2: c_half = `PCOC_HALF_DIV2;
            `PCOC_REF_DIV4: c_half = `PCOC_HALF_DIV4;
            default:        c_half = `PCOC_HALF_DIV1;
        endcase
        case (d_sel)
            `PCOC_REF_DIV2: d_half = `PCOC_HALF_DIV2;
            `PCOC_REF_DIV4: d_half = `PCOC_HALF_DIV4;
            default:        d_half = `PCOC_HALF_DIV1;
        endcase
    end

    pcoc_clk_div u_div_c
    (
        .clk         (clk),
        .rst_n       (rst_n),
        .enable      (c_sel != `PCOC_REF_OFF),
        .restart     (1'b0),
        .half_period (c_half),
        .clk_out     (ref_output_c),
        .active      (c_active)
    );

    // D is requested only while C is actually running
    pcoc_clk_div u_div_d
    (
        .clk         (clk),
        .rst_n       (rst_n),
        .enable      ((d_sel != `PCOC_REF_OFF) & c_active),
        .restart     (1'b0),
        .half_period (d_half),
        .clk_out     (ref_output_d),
        .active      (d_active)
    );

    // ------------------------------------------------------------------
    // Trigger output
    // ------------------------------------------------------------------
    assign aux_en       = auxctl_r[`PCOC_AUX_EN_BIT];
    assign aux_sel      = auxctl_r[`PCOC_AUX_SEL_MSB:0];
    assign aux_clk_mode = (aux_sel <= `PCOC_AUX_64UI);

    // Half period per select code
    always @*
    begin
        case (aux_sel)
            `PCOC_AUX_32UI: aux_half = `PCOC_HALF_32UI;
            `PCOC_AUX_64UI: aux_half = `PCOC_HALF_64UI;
            default:        aux_half = `PCOC_HALF_16UI;
        endcase
    end

    // Select change restarts the phase in case software ignores order
    always @(posedge clk)
    begin
        if (!rst_n)
            aux_sel_d_r <= `PCOC_AUX_16UI;
        else
            aux_sel_d_r <= aux_sel;
    end

    pcoc_clk_div u_div_aux
    (
        .clk         (clk),
        .rst_n       (rst_n),
        .enable      (aux_en & aux_clk_mode),
        .restart     (ser_reinit | (aux_sel != aux_sel_d_r)),
        .half_period (aux_half),
        .clk_out     (aux_clk),
        .active      ()
    );

    // Resampled timestamp; reserved codes hold the output low
    always @(posedge clk)
    begin
        if (!rst_n)
            tstamp_out_r <= 1'b0;
        else
            tstamp_out_r <= aux_en & (aux_sel == `PCOC_AUX_TSTAMP) &
                            tstamp_s;
    end

    assign aux_output_pin = aux_clk | tstamp_out_r;

endmodule

// >>> verif/pcoc_properties.sv
`timescale 1ns/10ps
module pcoc_properties
(
    input logic        clk,                   // System clock
    input logic        rst_n,                 // Sync reset
    input logic        spi_cs_n,              // Frame select
    input logic        spi_sdo_oe,            // Read drive enable
    input logic        synth_enable_pin,      // Enable pin
    input logic        ref_select_pin,        // Ref select pin
    input logic [6:0]  oscillator_bias_level, // Bias field
    input logic [31:0] lane_preemphasis,      // Lane settings
    input logic        synth_enable,          // Synth enable
    input logic        single_ended_ref_sel,  // Ref select
    input logic        aux_output_pin,        // Trigger output
    input logic        ref_output_c,          // Output C
    input logic        ref_output_d           // Output D
);
    logic [5:0] c_high_r;
    logic [5:0] d_high_r;
    logic [3:0] c_low_r;

    // Run lengths of the divided outputs
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            c_high_r <= 6'h00;
            d_high_r <= 6'h00;
            c_low_r  <= 4'h0;
        end
        else
        begin
            c_high_r <= ref_output_c ? c_high_r + 6'h01 : 6'h00;
            d_high_r <= ref_output_d ? d_high_r + 6'h01 : 6'h00;
            if (ref_output_c)
                c_low_r <= 4'h0;
            else if (c_low_r != 4'hF)
                c_low_r <= c_low_r + 4'h1;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // -----------------------------------------------------------
    // Checks
    // -----------------------------------------------------------
    a_lane_copy_all: assert property (
        lane_preemphasis == {8{lane_preemphasis[3:0]}})
        else $error("lane settings differ");
    a_reset_values: assert property (
        $rose(rst_n) |-> oscillator_bias_level == 7'h4F
        && lane_preemphasis == 32'h0 && !aux_output_pin
        && !ref_output_c && !ref_output_d && !synth_enable)
        else $error("outputs wrong after reset");
    a_c_half_width: assert property (
        $fell(ref_output_c) |-> c_high_r inside {6'h01, 6'h02, 6'h04})
        else $error("output C pulse width wrong");
    a_d_half_width: assert property (
        $fell(ref_output_d) |-> d_high_r inside {6'h01, 6'h02, 6'h04})
        else $error("output D pulse width wrong");
    a_d_needs_c: assert property (
        c_low_r >= 4'hC |-> !ref_output_d)
        else $error("output D runs without C");
    a_synth_en_cause: assert property (
        $changed(synth_enable) |-> !spi_cs_n || !$past(spi_cs_n, 4)
        || synth_enable == $past(synth_enable_pin, 4)
        || synth_enable == $past(synth_enable_pin, 2))
        else $error("synth enable changed without cause");
    a_ref_sel_cause: assert property (
        $changed(single_ended_ref_sel) |-> !spi_cs_n
        || !$past(spi_cs_n, 4)
        || single_ended_ref_sel == $past(ref_select_pin, 4)
        || single_ended_ref_sel == $past(ref_select_pin, 2))
        else $error("ref select changed without cause");
    a_regs_in_frame: assert property (
        $changed(oscillator_bias_level) || $changed(lane_preemphasis)
        |-> !spi_cs_n)
        else $error("setting changed outside a frame");
    a_sdo_released: assert property (
        spi_cs_n [*5] |-> !spi_sdo_oe)
        else $error("data out driven while deselected");
endmodule

bind pcoc_top pcoc_properties chk
(
    .clk(clk), .rst_n(rst_n), .spi_cs_n(spi_cs_n),
    .spi_sdo_oe(spi_sdo_oe), .synth_enable_pin(synth_enable_pin),
    .ref_select_pin(ref_select_pin),
    .oscillator_bias_level(oscillator_bias_level),
    .lane_preemphasis(lane_preemphasis), .synth_enable(synth_enable),
    .single_ended_ref_sel(single_ended_ref_sel),
    .aux_output_pin(aux_output_pin), .ref_output_c(ref_output_c),
    .ref_output_d(ref_output_d)
);

// >>> verif/pcoc_host_model.sv
`timescale 1ns/10ps
module pcoc_host_model
(
    input  logic clk,              // System clock
    output logic spi_sclk = 1'b0,  // Serial clock, still between frames
    output logic spi_cs_n = 1'b1,  // Frame select
    output logic spi_sdi  = 1'b0,  // Serial data to the block
    input  logic spi_sdo           // Serial data from the block
);
    logic [2:0] aux_sel_r = 3'h0;

    // One 24-bit frame, phases of five clocks, read bits taken on rise
    task automatic xfer(input logic rd, input logic [14:0] a,
                        input logic [7:0] d, output logic [7:0] q);
        logic [23:0] f;
        f = {rd, a, d};
        q = 8'h00;
        @(posedge clk);
        spi_cs_n <= 1'b0;
        for (int i = 23; i >= 0; i--)
        begin
            spi_sdi <= f[i];
            repeat (5) @(posedge clk);
            spi_sclk <= 1'b1;
            if (i < 8)
                q[i] = spi_sdo;
            repeat (5) @(posedge clk);
            spi_sclk <= 1'b0;
        end
        repeat (5) @(posedge clk);
        spi_cs_n <= 1'b1;
        spi_sdi  <= ~f[0];
        repeat (5) @(posedge clk);
    endtask

    // Bias writes are wrapped in the synthesizer reset
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        logic [7:0] q;
        if (a == 15'h003F)
            xfer(1'b0, 15'h005C, 8'h01, q);
        xfer(1'b0, a, d, q);
        if (a == 15'h003F)
            xfer(1'b0, 15'h005C, 8'h00, q);
    endtask

    task automatic rd(input logic [14:0] a, output logic [7:0] q);
        xfer(1'b1, a, 8'h00, q);
    endtask

    // Select moves only while the output is off, reserved bits zero
    task automatic set_aux(input logic en, input logic [2:0] s);
        wr(15'h0057, {5'h00, aux_sel_r});
        wr(15'h0057, {5'h00, s});
        wr(15'h0057, {en, 4'h0, s});
        aux_sel_r = s;
    endtask
endmodule

// >>> verif/testbench.sv
`timescale 1ns/10ps
module testbench;
    typedef struct packed
    {
        logic        w;
        logic [14:0] a;
        logic [7:0]  d;
        logic [7:0]  e;
    } pcoc_row_t;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic en_pin = 1'b0;
    logic sel_pin = 1'b0;
    logic cfg0 = 1'b0;
    logic cfg1 = 1'b0;
    logic tstamp = 1'b0;
    logic reinit = 1'b0;
    logic sclk, cs_n, sdi, sdo, sdo_oe, syn_en, se_sel, aux, out_c, out_d;
    logic [6:0]  bias;
    logic [31:0] lanes;
    logic [7:0]  q;
    logic [31:0] w;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    int n;
    int hv[4] = '{0, 1, 2, 4};
    pcoc_row_t rows[9] = '{
        '{1'b0, 15'h003F, 8'h00, 8'h4F}, '{1'b0, 15'h0048, 8'h00, 8'h00},
        '{1'b0, 15'h0057, 8'h00, 8'h00}, '{1'b0, 15'h0058, 8'h00, 8'h00},
        '{1'b1, 15'h003F, 8'h4A, 8'h4A}, '{1'b1, 15'h0048, 8'h05, 8'h05},
        '{1'b1, 15'h0048, 8'hFA, 8'h0A}, '{1'b1, 15'h0057, 8'h02, 8'h02},
        '{1'b1, 15'h005C, 8'h01, 8'h00}};

    always #12.5 clk = ~clk;

    pcoc_top dut
    (
        .clk(clk), .rst_n(rst_n), .spi_sclk(sclk), .spi_cs_n(cs_n),
        .spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe(sdo_oe),
        .synth_enable_pin(en_pin), .ref_select_pin(sel_pin),
        .clock_config_pin_0(cfg0), .clock_config_pin_1(cfg1),
        .timestamp_input(tstamp), .ser_reinit(reinit),
        .oscillator_bias_level(bias), .lane_preemphasis(lanes),
        .synth_enable(syn_en), .single_ended_ref_sel(se_sel),
        .aux_output_pin(aux), .ref_output_c(out_c), .ref_output_d(out_d)
    );

    pcoc_host_model host
    (
        .clk(clk), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_sdi(sdi),
        .spi_sdo(sdo)
    );

    // -----------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task print_verdict;
        $display("Checks %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task tick;
        @(posedge clk);
        #1;
    endtask

    function automatic logic pick(input int s);
        pick = (s == 0) ? out_c : (s == 1) ? out_d : aux;
    endfunction

    // Length of the next complete high phase
    task automatic high_width(input int s, output logic [31:0] hw);
        int k;
        hw = 0;
        k = 0;
        while (pick(s) !== 1'b0 && k++ < 300)
            tick();
        while (pick(s) !== 1'b1 && k++ < 300)
            tick();
        while (pick(s) === 1'b1 && k++ < 300)
        begin
            tick();
            hw++;
        end
    endtask

    task automatic stays_low(input int s);
        logic seen;
        seen = 1'b0;
        repeat (40)
        begin
            tick();
            seen = seen | pick(s);
        end
        check(seen, 1'b0);
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            mismatches++;
            print_verdict();
        end
    end

    // -----------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) tick();
        foreach (rows[i])
        begin
            if (rows[i].w)
                host.wr(rows[i].a, rows[i].d);
            host.rd(rows[i].a, q);
            check(q, rows[i].e);
        end
        check(lanes, 32'hAAAAAAAA);
        check(bias, 7'h4A);
        // Pin mode with a D field that must be ignored
        host.wr(15'h0058, 8'h30);
        @(posedge clk);
        {en_pin, sel_pin, cfg1, cfg0} <= 4'hE;
        repeat (10) tick();
        check({syn_en, se_sel}, 2'h3);
        high_width(0, w);
        check(w, 2);
        high_width(1, w);
        check(w, 2);
        @(posedge clk);
        {en_pin, cfg1, cfg0} <= 3'h1;
        repeat (10) tick();
        high_width(0, w);
        check(w, 1);
        stays_low(1);
        // Register control of every C and D code
        for (int k = 0; k < 4; k++)
        begin
            host.wr(15'h0058, {2'h2, k[1:0], (k == 0) ? 2'h3 : k[1:0], 2'h1});
            check({syn_en, se_sel}, 2'h2);
            high_width(0, w);
            check(w, (k == 0) ? 4 : hv[k]);
            if (k == 0)
                stays_low(1);
            else
            begin
                high_width(1, w);
                check(w, hv[k]);
            end
        end
        host.wr(15'h0058, 8'h90);
        stays_low(0);
        stays_low(1);
        host.wr(15'h0058, 8'h00);
        repeat (6) tick();
        check({syn_en, se_sel}, 2'h1);
        // Trigger output clock modes, restart and disable
        for (int s = 0; s < 3; s++)
        begin
            host.set_aux(1'b1, s[2:0]);
            high_width(2, w);
            check(w, 8 << s);
        end
        for (n = 0; n < 100 && aux !== 1'b1; n++)
            tick();
        @(posedge clk);
        reinit <= 1'b1;
        @(posedge clk);
        reinit <= 1'b0;
        tick();
        check(aux, 1'b0);
        high_width(2, w);
        check(w, 32);
        host.set_aux(1'b0, 3'h2);
        stays_low(2);
        // Resampled timestamp follows its pin
        host.set_aux(1'b1, 3'h3);
        @(posedge clk);
        tstamp <= 1'b1;
        repeat (8) tick();
        check(aux, 1'b1);
        // Reserved select code 4 keeps the output quiet
        host.set_aux(1'b1, 3'h4);
        stays_low(2);
        host.set_aux(1'b1, 3'h3);
        @(posedge clk);
        tstamp <= 1'b0;
        repeat (8) tick();
        check(aux, 1'b0);
        // Mid-run reset returns every setting to its default
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) tick();
        check(bias, 7'h4F);
        check(lanes, 32'h0);
        check({aux, syn_en}, 2'h0);
        host.rd(15'h0057, q);
        check(q, 8'h00);
        print_verdict();
    end
endmodule
